// >>> rtl/mri_phy.sv
// Purpose: phy end of the mii/rmii mac data link with receive elastic fifo
// Assumes: mri_sync from the mac end file is compiled first
// Notes: rmii frames wait in the fifo until the prefill level is reached
//
// Behaviour
// - mii moves one 4-bit nibble per clock
// - phy drives mii transmit and receive clocks
// - decode tx enable/error into idle, data, error
// - encode receive valid/error, false carrier, reserved
// - mac always drives all mii transmit pins
// - rmii follower clock comes from mac side
// - rmii leader drives clock on receive bit three
// - rmii moves two bits per clock each way
// - rmii tx enable marks data, else idle
// - rmii receive carrier/valid and error encoding
// - follower samples and presents on reference rises
// - leader samples and presents on own clock rises
// - rmii also outputs separate receive valid
// - rmii still drives receive error output
// - rmii fifo depth set by two register fields
// - long depth setting adds latency, longer frames
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// receive fifo
// ---------------------------------------------------------------------
module mri_fifo #(
   parameter int W = mri_pkg::FIFO_W,
   parameter int DEPTH = mri_pkg::FIFO_DEPTH
) (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic in_valid, // word offered
   output logic in_ready, // space available
   input wire logic [W-1:0] in_data, // word in
   output logic out_valid, // word available
   input wire logic out_ready, // word taken
   output logic [W-1:0] out_data, // head word
   output logic [$clog2(DEPTH):0] count // words held
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two");
   end

   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic push;
   logic pop;

   assign count = wr_r - rd_r;
   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem_r[rd_r[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointers carry a wrap bit so full and empty are told apart
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
      end
   end

   // storage has no reset; only words below the pointers are read
   always_ff @(posedge clk) begin
      if (push) mem_r[wr_r[AW-1:0]] <= in_data;
   end
endmodule : mri_fifo

// ---------------------------------------------------------------------
// phy end
// ---------------------------------------------------------------------
module mri_phy #(parameter int LINK_HALF = mri_pkg::LINK_HALF) (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic strap_mii, // 1 selects mii
   input wire logic strap_leader, // rmii only: 1 selects leader clocking
   mri_if.phy link, // pins toward the mac
   input wire logic [15:0] reg_addr, // register address
   input wire logic [15:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   output logic [15:0] reg_rdata, // read data, one cycle after address
   input wire logic line_rx_valid, // line word offered
   output logic line_rx_ready, // fifo has room
   input wire logic line_rx_dv, // word is frame data
   input wire logic line_rx_er, // word errored / false carrier
   input wire logic [3:0] line_rx_data, // line nibble
   output logic line_tx_valid, // transmit nibble pulse
   output logic [3:0] line_tx_data, // transmit nibble
   output logic line_tx_err, // nibble carries error propagation
   output logic line_tx_active // transmit enable level
);
   if (LINK_HALF < 4 || LINK_HALF > 255) begin : g_chk
      $error("LINK_HALF out of range");
   end

   localparam int CW = $clog2(mri_pkg::FIFO_DEPTH) + 1;

   logic [1:0] strap_q;
   logic [1:0] st_cnt_r;
   logic mode_ok_r;
   mri_pkg::mri_mode_t mode_r;
   mri_pkg::mri_mode_t mode_nxt;
   logic is_mii;
   logic is_fol;
   logic is_lead;
   logic [7:0] div_r;
   logic gclk_r;
   logic own_tick;
   logic [6:0] pin_q;
   logic ref_prev_r;
   logic beat;
   logic [1:0] pri_r;
   logic [2:0] sec_r;
   logic [15:0] rdata_r;
   logic [2:0] prefill;
   logic ltx_valid_r;
   logic [3:0] ltx_data_r;
   logic ltx_err_r;
   logic ltx_active_r;
   logic tx_ph_r;
   logic [1:0] tx_lo_r;
   logic fo_valid;
   logic fo_ready;
   logic [5:0] fo_data;
   logic [CW-1:0] fo_count;
   logic rx_ph_r;
   logic in_frame_r;
   logic [1:0] rx_hi_r;
   logic [3:0] rxd_r;
   logic rx_dv_r;
   logic rx_er_r;
   logic nib_beat;
   logic head_go;

   mri_sync #(.W(2)) u_strap (
      .clk(clk),
      .rst_b(rst_b),
      .d({strap_mii, strap_leader}),
      .q(strap_q)
   );

   always_comb begin
      if (strap_q[1]) mode_nxt = mri_pkg::MODE_MII;
      else if (strap_q[0]) mode_nxt = mri_pkg::MODE_RMII_LEAD;
      else mode_nxt = mri_pkg::MODE_RMII_FOL;
   end

   // interface type and clocking role are fixed once after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_cnt_r <= 2'h0;
         mode_r <= mri_pkg::MODE_MII;
         mode_ok_r <= 1'b0;
      end else if (!mode_ok_r) begin
         if (st_cnt_r == 2'(mri_pkg::STRAP_WAIT)) begin
            mode_r <= mode_nxt;
            mode_ok_r <= 1'b1;
         end else begin
            st_cnt_r <= st_cnt_r + 2'h1;
         end
      end
   end
   assign is_mii = mode_r == mri_pkg::MODE_MII;
   assign is_fol = mode_r == mri_pkg::MODE_RMII_FOL;
   assign is_lead = mode_r == mri_pkg::MODE_RMII_LEAD;

   // own link clock for mii and rmii leader
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 8'h0;
         gclk_r <= 1'b0;
      end else if (own_tick) begin
         div_r <= 8'h0;
         gclk_r <= ~gclk_r;
      end else begin
         div_r <= div_r + 8'h1;
      end
   end
   assign own_tick = div_r == 8'(LINK_HALF - 1);
   assign link.tx_clk = mode_ok_r && is_mii && gclk_r;
   assign link.rx_clk = mode_ok_r && is_mii && gclk_r;

   // mac-driven pins and the follower reference pass two flops
   mri_sync #(.W(7)) u_pins (
      .clk(clk),
      .rst_b(rst_b),
      .d({link.ref_clk, link.tx_er, link.tx_en, link.txd}),
      .q(pin_q)
   );
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) ref_prev_r <= 1'b0;
      else ref_prev_r <= pin_q[6];
   end
   // one rising-edge event drives both directions
   assign beat = mode_ok_r &&
      (is_fol ? (pin_q[6] && !ref_prev_r) : (own_tick && !gclk_r));

   // depth registers; only the documented fields are stored
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pri_r <= mri_pkg::PRI_RST;
         sec_r <= mri_pkg::SEC_RST;
      end else if (reg_wr && reg_addr == mri_pkg::REG_FIFO_PRI) begin
         pri_r <= reg_wdata[mri_pkg::PRI_LSB +: mri_pkg::PRI_W];
      end else if (reg_wr && reg_addr == mri_pkg::REG_FIFO_SEC) begin
         sec_r <= reg_wdata[mri_pkg::SEC_LSB +: mri_pkg::SEC_W];
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) rdata_r <= 16'h0;
      else if (reg_addr == mri_pkg::REG_FIFO_PRI) rdata_r <= {6'h0, pri_r, 8'h0};
      else if (reg_addr == mri_pkg::REG_FIFO_SEC) rdata_r <= {6'h0, sec_r, 7'h0};
      else rdata_r <= 16'h0;
   end
   assign reg_rdata = rdata_r;
   // any pair other than the long one behaves as the default
   assign prefill = (pri_r == mri_pkg::PRI_LONG && sec_r == mri_pkg::SEC_LONG) ?
      mri_pkg::PREFILL_LONG : mri_pkg::PREFILL_DEF;

   // transmit decode toward the line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ltx_valid_r <= 1'b0;
         ltx_data_r <= 4'h0;
         ltx_err_r <= 1'b0;
         ltx_active_r <= 1'b0;
         tx_ph_r <= 1'b0;
         tx_lo_r <= 2'h0;
      end else begin
         ltx_valid_r <= 1'b0;
         if (beat) begin
            ltx_active_r <= pin_q[4];
            if (is_mii && pin_q[4]) begin
               ltx_valid_r <= 1'b1;
               ltx_data_r <= pin_q[3:0];
               ltx_err_r <= pin_q[5];
            end else if (!is_mii && pin_q[4] && tx_ph_r) begin
               ltx_valid_r <= 1'b1;
               ltx_data_r <= {pin_q[1:0], tx_lo_r};
               ltx_err_r <= 1'b0;
               tx_ph_r <= 1'b0;
            end else if (!is_mii && pin_q[4]) begin
               tx_lo_r <= pin_q[1:0];
               tx_ph_r <= 1'b1;
            end else begin
               tx_ph_r <= 1'b0; // an odd dibit at frame end is dropped
            end
         end
      end
   end
   assign line_tx_valid = ltx_valid_r;
   assign line_tx_data = ltx_data_r;
   assign line_tx_err = ltx_err_r;
   assign line_tx_active = ltx_active_r;

   // elastic buffer between line timing and the mac reference
   mri_fifo #(.W(mri_pkg::FIFO_W), .DEPTH(mri_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(line_rx_valid),
      .in_ready(line_rx_ready),
      .in_data({line_rx_dv, line_rx_er, line_rx_data}),
      .out_valid(fo_valid),
      .out_ready(fo_ready),
      .out_data(fo_data),
      .count(fo_count)
   );

   // a new nibble is due every mii beat; in rmii every second beat within a frame, every beat between frames
   assign nib_beat = beat && (is_mii || !rx_ph_r);
   // an rmii frame head waits for the prefill level; trades latency for slack
   assign head_go = !fo_data[5] || in_frame_r || is_mii ||
      fo_count >= CW'(prefill);
   assign fo_ready = nib_beat && fo_valid && head_go;

   // receive presentation toward the mac, on the rising beat
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxd_r <= 4'h0;
         rx_dv_r <= 1'b0;
         rx_er_r <= 1'b0;
         rx_hi_r <= 2'h0;
         rx_ph_r <= 1'b0;
         in_frame_r <= 1'b0;
      end else if (beat && rx_ph_r) begin
         rxd_r <= {2'h0, rx_hi_r};
         rx_ph_r <= 1'b0;
      end else if (nib_beat && !fo_ready) begin
         rxd_r <= mri_pkg::NIB_IDLE;
         rx_dv_r <= 1'b0;
         rx_er_r <= 1'b0;
         in_frame_r <= 1'b0;
      end else if (nib_beat && is_mii) begin
         rxd_r <= fo_data[3:0];
         rx_dv_r <= fo_data[5];
         // reserved idle codes go out with the error line low
         rx_er_r <= fo_data[4] && (fo_data[5] || fo_data[3:0] == mri_pkg::NIB_IDLE ||
            fo_data[3:0] == mri_pkg::NIB_FALSE_CARRIER);
         in_frame_r <= fo_data[5];
      end else if (nib_beat) begin
         rxd_r <= {2'h0, fo_data[1:0]};
         rx_hi_r <= fo_data[3:2];
         rx_dv_r <= fo_data[5];
         rx_er_r <= fo_data[4] && fo_data[5];
         rx_ph_r <= fo_data[5];
         in_frame_r <= fo_data[5];
      end
   end
   // the leader clock replaces data bit three
   assign link.rxd = {(mode_ok_r && is_lead) ? gclk_r : rxd_r[3], rxd_r[2:0]};
   assign link.rx_dv = rx_dv_r;
   assign link.rx_er = rx_er_r;
   assign link.crs_dv = !is_mii && rx_dv_r;
endmodule : mri_phy
`default_nettype wire

// >>> rtl/mri_pkg.sv
// Purpose: shared constants and types for the mii/rmii mac data link
// Assumes: both ends run on a 200 MHz clk and oversample the link clocks
// Notes: link clocks are slowed by LINK_HALF so two-flop sampling keeps margin
package mri_pkg;
   // ------------------------------------------------------------------
   // fifo depth registers
   // ------------------------------------------------------------------
   localparam logic [15:0] REG_FIFO_PRI = 16'h0011;
   localparam logic [15:0] REG_FIFO_SEC = 16'h0648;
   localparam int PRI_LSB = 8;
   localparam int PRI_W = 2;
   localparam int SEC_LSB = 7;
   localparam int SEC_W = 3;
   localparam logic [1:0] PRI_RST = 2'h1;
   localparam logic [1:0] PRI_LONG = 2'h2;
   localparam logic [2:0] SEC_RST = 3'h2;
   localparam logic [2:0] SEC_LONG = 3'h4;
   localparam int RMII_PERIOD_NS = 20;
   localparam int LONG_LAT_NS = 80;
   localparam logic [2:0] PREFILL_DEF = 3'h1;
   // extra nibbles held back by the long setting: 80 ns of dibits at 50 MHz
   localparam logic [2:0] PREFILL_LONG =
      3'(int'(PREFILL_DEF) + LONG_LAT_NS / (2 * RMII_PERIOD_NS));

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LINK_PERIOD_NS = 80;
   localparam int LINK_HALF = (LINK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
   localparam int STRAP_WAIT = 2;

   // ------------------------------------------------------------------
   // data encodings and storage
   // ------------------------------------------------------------------
   localparam logic [3:0] NIB_FALSE_CARRIER = 4'he;
   localparam logic [3:0] NIB_IDLE = 4'h0;
   localparam logic [1:0] DIB_IDLE = 2'h0;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_W = 6;

   typedef enum logic [1:0] {MODE_MII, MODE_RMII_FOL, MODE_RMII_LEAD} mri_mode_t;
endpackage : mri_pkg

// >>> rtl/mri_if.sv
// Purpose: pin bundle between the phy end and the mac end
// Assumes: rmii uses txd[1:0]/rxd[1:0]; rmii leader clock rides on rxd[3]
// Notes: ref_clk is the reference clock input pin of the phy
`timescale 1ns/100ps
`default_nettype none
interface mri_if;
   logic tx_clk;
   logic rx_clk;
   logic ref_clk;
   logic [3:0] txd;
   logic tx_en;
   logic tx_er;
   logic [3:0] rxd;
   logic rx_dv;
   logic rx_er;
   logic crs_dv;

   modport phy (input txd, tx_en, tx_er, ref_clk,
                output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs_dv);
   modport mac (output txd, tx_en, tx_er, ref_clk,
                input tx_clk, rx_clk, rxd, rx_dv, rx_er, crs_dv);
endinterface : mri_if
`default_nettype wire

// >>> rtl/mri_mac.sv
// Purpose: mac end of the link plus the shared two-flop pin synchroniser
// Assumes: mode straps are static around reset release
// Notes: transmit pins change on link clock falls, receive pins sampled on rises
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// two-flop synchroniser
// ---------------------------------------------------------------------
module mri_sync #(parameter int W = 1) (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous pins
   output logic [W-1:0] q // synchronised copy
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
   assign q = q_r;
endmodule : mri_sync

// ---------------------------------------------------------------------
// mac end
// ---------------------------------------------------------------------
module mri_mac #(parameter int LINK_HALF = mri_pkg::LINK_HALF) (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic strap_mii, // 1 selects mii
   input wire logic strap_leader, // rmii only: 1 selects leader clocking
   mri_if.mac link, // pins toward the phy
   input wire logic tx_valid, // nibble offered
   output logic tx_ready, // nibble taken this cycle
   input wire logic [3:0] tx_data, // nibble to send
   input wire logic tx_err, // mii error propagation
   output logic rx_valid, // received nibble pulse
   output logic [3:0] rx_data, // received nibble
   output logic rx_err, // nibble received with error
   output logic rx_false_carrier, // false carrier pulse
   output logic rx_active // carrier / data valid level
);
   if (LINK_HALF < 4 || LINK_HALF > 255) begin : g_chk
      $error("LINK_HALF out of range");
   end

   logic [1:0] strap_q;
   logic [1:0] st_cnt_r;
   logic mode_ok_r;
   mri_pkg::mri_mode_t mode_r;
   mri_pkg::mri_mode_t mode_nxt;
   logic is_mii;
   logic is_fol;
   logic [7:0] div_r;
   logic gclk_r;
   logic own_tick;
   logic [8:0] pin_q;
   logic txck;
   logic rxck;
   logic txck_prev_r;
   logic rxck_prev_r;
   logic tx_beat;
   logic rx_beat;
   logic [3:0] txd_r;
   logic tx_en_r;
   logic tx_er_r;
   logic tx_ph_r;
   logic [1:0] tx_hi_r;
   logic rx_valid_r;
   logic [3:0] rx_data_r;
   logic rx_err_r;
   logic rx_fc_r;
   logic rx_active_r;
   logic rx_ph_r;
   logic [1:0] rx_lo_r;
   logic rx_erlo_r;

   // straps are pins, so they are synchronised before capture
   mri_sync #(.W(2)) u_strap (
      .clk(clk),
      .rst_b(rst_b),
      .d({strap_mii, strap_leader}),
      .q(strap_q)
   );

   always_comb begin
      if (strap_q[1]) mode_nxt = mri_pkg::MODE_MII;
      else if (strap_q[0]) mode_nxt = mri_pkg::MODE_RMII_LEAD;
      else mode_nxt = mri_pkg::MODE_RMII_FOL;
   end

   // one interface and one clocking role, caught once after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_cnt_r <= 2'h0;
         mode_r <= mri_pkg::MODE_MII;
         mode_ok_r <= 1'b0;
      end else if (!mode_ok_r) begin
         if (st_cnt_r == 2'(mri_pkg::STRAP_WAIT)) begin
            mode_r <= mode_nxt;
            mode_ok_r <= 1'b1;
         end else begin
            st_cnt_r <= st_cnt_r + 2'h1;
         end
      end
   end
   assign is_mii = mode_r == mri_pkg::MODE_MII;
   assign is_fol = mode_r == mri_pkg::MODE_RMII_FOL;

   // reference clock divider, used only as rmii follower
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 8'h0;
         gclk_r <= 1'b0;
      end else if (own_tick) begin
         div_r <= 8'h0;
         gclk_r <= ~gclk_r;
      end else begin
         div_r <= div_r + 8'h1;
      end
   end
   assign own_tick = div_r == 8'(LINK_HALF - 1);
   assign link.ref_clk = mode_ok_r && is_fol && gclk_r;

   // all phy-driven pins pass two flops
   mri_sync #(.W(9)) u_pins (
      .clk(clk),
      .rst_b(rst_b),
      .d({link.tx_clk, link.rx_clk, link.crs_dv, link.rx_er, link.rx_dv, link.rxd}),
      .q(pin_q)
   );

   // mii uses the phy clocks, rmii leader the clock on rxd[3]
   assign txck = is_mii ? pin_q[8] : pin_q[3];
   assign rxck = is_mii ? pin_q[7] : pin_q[3];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txck_prev_r <= 1'b0;
         rxck_prev_r <= 1'b0;
      end else begin
         txck_prev_r <= txck;
         rxck_prev_r <= rxck;
      end
   end
   // driving on falls keeps data stable across the rising sample edge
   assign tx_beat = mode_ok_r && (is_fol ? (own_tick && gclk_r) : (txck_prev_r && !txck));
   assign rx_beat = mode_ok_r && (is_fol ? (own_tick && !gclk_r) : (!rxck_prev_r && rxck));
   assign tx_ready = tx_beat && (is_mii || !tx_ph_r);

   // transmit: one nibble per mii beat, two dibits per nibble in rmii, low first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txd_r <= 4'h0;
         tx_en_r <= 1'b0;
         tx_er_r <= 1'b0;
         tx_ph_r <= 1'b0;
         tx_hi_r <= 2'h0;
      end else if (tx_beat) begin
         if (is_mii) begin
            tx_en_r <= tx_valid;
            tx_er_r <= tx_valid && tx_err;
            txd_r <= tx_valid ? tx_data : mri_pkg::NIB_IDLE;
         end else if (tx_ph_r) begin
            txd_r <= {2'h0, tx_hi_r};
            tx_ph_r <= 1'b0;
         end else begin
            tx_en_r <= tx_valid;
            tx_er_r <= 1'b0;
            txd_r <= {2'h0, tx_valid ? tx_data[1:0] : mri_pkg::DIB_IDLE};
            tx_hi_r <= tx_data[3:2];
            tx_ph_r <= tx_valid;
         end
      end
   end
   // every transmit pin is always driven, never left floating
   assign link.txd = txd_r;
   assign link.tx_en = tx_en_r;
   assign link.tx_er = tx_er_r;

   // receive: decode on each sampled rising edge of the link clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_valid_r <= 1'b0;
         rx_data_r <= 4'h0;
         rx_err_r <= 1'b0;
         rx_fc_r <= 1'b0;
         rx_active_r <= 1'b0;
         rx_ph_r <= 1'b0;
         rx_lo_r <= 2'h0;
         rx_erlo_r <= 1'b0;
      end else begin
         rx_valid_r <= 1'b0;
         rx_fc_r <= 1'b0;
         if (rx_beat && is_mii) begin
            rx_active_r <= pin_q[4];
            if (pin_q[4]) begin
               rx_valid_r <= 1'b1;
               rx_data_r <= pin_q[3:0];
               rx_err_r <= pin_q[5];
            end else if (pin_q[5] && pin_q[3:0] == mri_pkg::NIB_FALSE_CARRIER) begin
               rx_fc_r <= 1'b1;
            end
         end else if (rx_beat) begin
            rx_active_r <= pin_q[6];
            // the separate valid pin avoids splitting carrier from data
            if (!pin_q[4]) begin
               rx_ph_r <= 1'b0;
            end else if (rx_ph_r) begin
               rx_valid_r <= 1'b1;
               rx_data_r <= {pin_q[1:0], rx_lo_r};
               rx_err_r <= rx_erlo_r || pin_q[5];
               rx_ph_r <= 1'b0;
            end else begin
               rx_lo_r <= pin_q[1:0];
               rx_erlo_r <= pin_q[5];
               rx_ph_r <= 1'b1;
            end
         end
      end
   end
   assign rx_valid = rx_valid_r;
   assign rx_data = rx_data_r;
   assign rx_err = rx_err_r;
   assign rx_false_carrier = rx_fc_r;
   assign rx_active = rx_active_r;
endmodule : mri_mac
`default_nettype wire

// >>> verif/mri_link_checker.sv
// Purpose: pin checks on the link between the mac and phy ends
// Assumes: mode is read from which link clock toggles
// Notes: only the mii clock divider is timed
`timescale 1ns/100ps
`default_nettype none
module mri_link_checker #(parameter int LINK_HALF = 4) (
   input wire logic clk, // clock
   input wire logic rst_b, // reset
   input wire logic tx_clk, // mii tx clk
   input wire logic rx_clk, // mii rx clk
   input wire logic ref_clk, // rmii ref
   input wire logic [3:0] txd, // tx data
   input wire logic tx_en, // tx enable
   input wire logic tx_er, // tx error
   input wire logic [3:0] rxd, // rx data
   input wire logic rx_dv, // rx valid
   input wire logic rx_er, // rx error
   input wire logic crs_dv // carrier
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic clk_q_r, seen_r;
   logic [7:0] cnt_r;
   // phase counter; seen_r skips the partial first phase after mode capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_q_r <= 1'b0;
         seen_r <= 1'b0;
         cnt_r <= 8'h00;
      end else begin
         clk_q_r <= tx_clk;
         seen_r <= seen_r | (tx_clk != clk_q_r);
         cnt_r <= (tx_clk != clk_q_r) ? 8'h00 : cnt_r + 8'h01;
      end
   end
   AST_CLK_PAIR: assert property (rx_clk == tx_clk)
      else $error("rx and tx clocks differ");
   AST_HALF: assert property (seen_r && tx_clk != clk_q_r |-> cnt_r == 8'(LINK_HALF - 1))
      else $error("bad half period");
   AST_TX_HOLD: assert property ($rose(tx_clk) || $rose(ref_clk) |-> $stable({txd, tx_en}))
      else $error("tx pins move at rise");
   AST_RX_BEAT: assert property (seen_r && $changed({rxd, rx_dv}) |-> $rose(tx_clk))
      else $error("rx pins off beat");
   AST_CRS_DV: assert property (crs_dv |-> rx_dv)
      else $error("crs without valid");
   AST_BIT2: assert property (crs_dv |-> !rxd[2])
      else $error("rmii bit two set");
   AST_ONE_MODE: assert property (tx_clk |-> !crs_dv && !ref_clk)
      else $error("two modes at once");
   AST_IDLE_ER: assert property (rx_er && !rx_dv |-> rxd == 4'he || rxd == 4'h0)
      else $error("reserved idle code");
   cover property (rx_dv && rx_er);
   cover property (crs_dv);
   cover property (rx_er && !rx_dv);
endmodule : mri_link_checker
`default_nettype wire

// >>> verif/mii_rmii_mac_interface_tb.sv
// Purpose: both ends joined, traffic each way in all three modes
// Assumes: LINK_HALF 4 on both ends
// Notes: queues hold expected nibbles in send order
`timescale 1ns/100ps
`default_nettype none
module mii_rmii_mac_interface_tb;
   logic clk = 0, rst_b = 0, strap_mii = 0, strap_leader = 0, tx_valid = 0, tx_err = 0;
   logic reg_wr = 0, lrv = 0, ldv = 0, ler = 0, fc, tx_ready, rx_valid, rx_err, rx_fc;
   logic lr_ready, ltv, lte, rxa, lta;
   logic [3:0] tx_data = 0, ldata = 0, rx_data, ltd;
   logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, w;
   logic [31:0] dt, dr;
   logic [5:0] qt[$], qr[$];
   int fail_count = 0, check_count = 0, n_tx = 0, n_rx = 0, fc_exp, fc_got, m, i;
   mri_if link();
   mri_mac #(.LINK_HALF(4)) i_mri_mac(.clk(clk), .rst_b(rst_b), .strap_mii(strap_mii),
      .strap_leader(strap_leader), .link(link), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_err(tx_err), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_err(rx_err), .rx_false_carrier(rx_fc), .rx_active(rxa));
   mri_phy #(.LINK_HALF(4)) i_mri_phy(.clk(clk), .rst_b(rst_b), .strap_mii(strap_mii),
      .strap_leader(strap_leader), .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rdata(reg_rdata), .line_rx_valid(lrv), .line_rx_ready(lr_ready),
      .line_rx_dv(ldv), .line_rx_er(ler), .line_rx_data(ldata), .line_tx_valid(ltv),
      .line_tx_data(ltd), .line_tx_err(lte), .line_tx_active(lta));
   mri_link_checker #(.LINK_HALF(4)) i_chk(.clk(clk), .rst_b(rst_b), .tx_clk(link.tx_clk),
      .rx_clk(link.rx_clk), .ref_clk(link.ref_clk), .txd(link.txd), .tx_en(link.tx_en),
      .tx_er(link.tx_er), .rxd(link.rxd), .rx_dv(link.rx_dv), .rx_er(link.rx_er),
      .crs_dv(link.crs_dv));
   always #2.5 clk = ~clk;
   task automatic check(input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   task automatic wr(input logic [15:0] a, d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, e);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      check(reg_rdata, e);
   endtask : rd
   // mac user side: offer held until taken; rmii drops the error bit
   always @(posedge clk) begin
      if (n_tx > 0 && (!tx_valid || tx_ready)) begin
         dt = $urandom;
         {tx_err, tx_data} <= dt[4:0];
         tx_valid <= 1'b1;
         n_tx <= n_tx - 1;
         qt.push_back({1'b1, strap_mii & dt[4], dt[3:0]});
      end else if (tx_ready) tx_valid <= 1'b0;
   end
   // line side: each word held until the fifo takes it; mii also sends false carriers
   always @(posedge clk) begin
      if (n_rx > 0 && (!lrv || lr_ready)) begin
         dr = $urandom;
         fc = strap_mii && dr[7:5] == 3'h0;
         ldv <= !fc;
         ler <= fc | dr[4];
         ldata <= fc ? 4'he : dr[3:0];
         lrv <= 1'b1;
         n_rx <= n_rx - 1;
         if (fc) fc_exp++;
         else qr.push_back({1'b1, dr[4:0]});
      end else if (lr_ready) lrv <= 1'b0;
   end
   always @(posedge clk) begin
      if (ltv) check(16'({lta, lte, ltd}), qt.size() ? 16'(qt.pop_front()) : 'x);
      if (rx_valid) check(16'({rxa, rx_err, rx_data}), qr.size() ? 16'(qr.pop_front()) : 'x);
      if (rx_fc) fc_got++;
   end
   initial begin
      #50000;
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(85));
      for (m = 0; m < 3; m++) begin
         @(posedge clk);
         rst_b <= 1'b0;
         strap_mii <= (m == 0);
         strap_leader <= (m == 2);
         repeat (3) @(posedge clk);
         rst_b <= 1'b1;
         repeat (8) @(posedge clk);
         w = (m == 1) ? 16'h0200 : 16'($urandom);
         rd(16'h0011, 16'h0100);
         rd(16'h0648, 16'h0100);
         wr(16'h0011, w);
         wr(16'h0648, w);
         rd(16'h0011, w & 16'h0300);
         rd(16'h0648, w & 16'h0380);
         rd(16'h0012, 16'h0000);
         fc_exp = 0;
         fc_got = 0;
         n_tx <= 24;
         n_rx <= 24;
         @(posedge clk);
         for (i = 0; i < 3000 && n_tx + n_rx + qt.size() + qr.size() > 0; i++) @(posedge clk);
         check(16'(i == 3000), 16'h0000);
         repeat (40) @(posedge clk);
         check(16'(fc_got), 16'(fc_exp));
      end
      summarize();
   end
endmodule : mii_rmii_mac_interface_tb
`default_nettype wire
